// file: pkg/ddrtc_map.svh
// Register offsets, field positions, reset values and timing counts of the DDR timing block
`ifndef DDRTC_MAP_SVH
`define DDRTC_MAP_SVH

// Register byte offsets (low address byte)
`define DDRTC_CTRL_OFS 8'h00
`define DDRTC_STAT_OFS 8'h04
`define DDRTC_CLR_OFS 8'h08

// Control word fields
`define DDRTC_AL_LSB 0
`define DDRTC_AL_MSB 2
`define DDRTC_BL8_BIT 3
`define DDRTC_WR_LSB 4
`define DDRTC_WR_MSB 6
`define DDRTC_STROBE_BIT 10
`define DDRTC_SLOWX_BIT 12
`define DDRTC_GRADE_BIT 13
`define DDRTC_CFG_RST 10'h000

// Status word fields
`define DDRTC_VIOL_LSB 0
`define DDRTC_VIOL_MSB 5
`define DDRTC_PST_LSB 8
`define DDRTC_PST_MSB 9
`define DDRTC_FREQOK_BIT 10
`define DDRTC_TERM_BIT 11
`define DDRTC_BUSY_BIT 12
`define DDRTC_CLR_BIT 0

// Link clock and timing parameters in picoseconds, refresh interval in nanoseconds
`define DDRTC_LINK_TCK_PS 160000
`define DDRTC_PRECHARGE_PERIOD_PS 15000
`define DDRTC_ROW_ACTIVE_MIN_PS 45000
`define DDRTC_READ_TO_PRECHARGE_PS 7500
`define DDRTC_REFRESH_INTERVAL_NS 7800
`define DDRTC_RU(ps) (((ps) + `DDRTC_LINK_TCK_PS - 1) / `DDRTC_LINK_TCK_PS)
`define DDRTC_NRP_CYC `DDRTC_RU(`DDRTC_PRECHARGE_PERIOD_PS)
`define DDRTC_NRAS_CYC `DDRTC_RU(`DDRTC_ROW_ACTIVE_MIN_PS)
`define DDRTC_NRTP_CYC `DDRTC_RU(`DDRTC_READ_TO_PRECHARGE_PS)
`define DDRTC_REFI_CYC ((`DDRTC_REFRESH_INTERVAL_NS * 1000) / `DDRTC_LINK_TCK_PS)

// Counts in input clock edges
`define DDRTC_CKE_HOLD_CYC 3
`define DDRTC_WTR_CYC 2
`define DDRTC_XP_CYC 2
`define DDRTC_XARD_CYC 2
`define DDRTC_XARDS_SLOW_BASE 8
`define DDRTC_XARDS_FAST_BASE 7
`define DDRTC_AOND_CYC 2
`define DDRTC_AOFD_CYC 2

`endif

// file: pkg/ddrtc_pkg.sv
// Types of the DDR timing block
package ddrtc_pkg;

    typedef enum logic [1:0] {
        DDRTC_RUN = 2'h0,
        DDRTC_PDN_PRE = 2'h1,
        DDRTC_PDN_ACT = 2'h3,
        DDRTC_SELF_REF = 2'h2
    } ddrtc_pstate_t;

    typedef enum logic [2:0] {
        DDRTC_NOP = 3'h0,
        DDRTC_ACT = 3'h1,
        DDRTC_RD = 3'h2,
        DDRTC_WR = 3'h3,
        DDRTC_PRE = 3'h4,
        DDRTC_REF = 3'h5,
        DDRTC_MRS = 3'h6
    } ddrtc_cmd_t;

    typedef struct packed {
        logic cke;
        logic odt;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic ap;
        logic [2:0] bank;
    } ddrtc_pins_t;

    typedef struct packed {
        logic speed_fast;
        logic slow_exit;
        logic strobe_single;
        logic [2:0] write_recovery;
        logic bl8;
        logic [2:0] additive_latency;
    } ddrtc_cfg_t;

    typedef struct packed {
        logic refresh;
        logic pd_exit;
        logic dal;
        logic rtp;
        logic wtr;
        logic cke_hold;
    } ddrtc_viol_t;

    typedef struct packed {
        ddrtc_cfg_t cfg;
        logic cfg_ack;
        logic clr_prev;
        ddrtc_viol_t viol;
        ddrtc_pstate_t pstate;
        logic cke_prev;
        logic [1:0] cke_hold;
        logic odt_prev;
        logic [1:0] on_cnt;
        logic [1:0] off_cnt;
        logic term_on;
        logic off_due;
        logic [7:0] open_bank;
        logic [7:0][4:0] pre_cnt;
        logic [7:0][4:0] act_cnt;
        logic [1:0] wtr_cnt;
        logic [1:0] xp_cnt;
        logic [3:0] xrd_cnt;
        logic [15:0] ref_cnt;
    } ddrtc_link_st_t;

    typedef struct packed {
        ddrtc_cfg_t cfg;
        logic cfg_req;
        logic clr_req;
        logic dp_valid;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
    } ddrtc_bus_st_t;

endpackage : ddrtc_pkg

// file: src/ddrtc_sync.sv
// Two-flop synchroniser for independent level bits
`timescale 1ns/1ps
module ddrtc_sync #(
    parameter int W = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : ddrtc_sync

// file: src/ddrtc_top.sv
// DDR device command timing, termination timing and AHB-Lite register slave
// Operation
// - Mode bit 12 picks fast or slow active power-down exit to read.
// - Termination turns on two edges after first registered high control.
// - Termination turns off half period after second edge from first low.
// - Clock frequency may change only in self refresh or precharge power-down.
// - Differential strobe enabled when mode bit 10 is cleared.
// - Longer write strobe postamble accepted; only lengthens bus turnaround.
`timescale 1ns/1ps
`include "ddrtc_map.svh"
module ddrtc_top (
    // AHB-Lite clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Memory link, sampled on the controller clock
    input wire logic mem_clk,
    input wire ddrtc_pkg::ddrtc_pins_t link_pins,
    // Device pins steered by the block
    output logic term_active,
    output logic diff_strobe_en
);
    ddrtc_pkg::ddrtc_bus_st_t bq;
    ddrtc_pkg::ddrtc_bus_st_t bn;
    ddrtc_pkg::ddrtc_link_st_t lq;
    ddrtc_pkg::ddrtc_link_st_t ln;
    logic off_half_reg;
    logic link_rst_n;
    logic [1:0] req_s;
    logic [10:0] stat_s;
    logic busy;
    ddrtc_pkg::ddrtc_cmd_t cmd;
    ddrtc_pkg::ddrtc_viol_t vset;
    logic [4:0] burst_half;
    logic [4:0] rd_load;
    logic [3:0] xard_slow;
    logic [7:0] bank_hit;
    logic cke_rise;
    logic cke_fall;

    function automatic ddrtc_pkg::ddrtc_cmd_t decode_cmd(input ddrtc_pkg::ddrtc_pins_t p);
        ddrtc_pkg::ddrtc_cmd_t c;
        c = ddrtc_pkg::DDRTC_NOP;
        if (!p.cs_n) begin
            case ({p.ras_n, p.cas_n, p.we_n})
                3'h3: c = ddrtc_pkg::DDRTC_ACT;
                3'h5: c = ddrtc_pkg::DDRTC_RD;
                3'h4: c = ddrtc_pkg::DDRTC_WR;
                3'h2: c = ddrtc_pkg::DDRTC_PRE;
                3'h1: c = ddrtc_pkg::DDRTC_REF;
                3'h0: c = ddrtc_pkg::DDRTC_MRS;
                default: c = ddrtc_pkg::DDRTC_NOP;
            endcase
        end
        return c;
    endfunction : decode_cmd

    // Register index: 0 ctrl, 1 status, 2 clear, 3 unmapped
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        logic [1:0] s;
        s = 2'h3;
        if (a == `DDRTC_CTRL_OFS) begin
            s = 2'h0;
        end else if (a == `DDRTC_STAT_OFS) begin
            s = 2'h1;
        end else if (a == `DDRTC_CLR_OFS) begin
            s = 2'h2;
        end
        return s;
    endfunction : reg_sel

    // Link reset is released in step with the link clock
    ddrtc_sync #(.W(1)) u_rst_sync (
        .clk(mem_clk),
        .rst_n(hresetn),
        .d(1'b1),
        .q(link_rst_n)
    );

    ddrtc_sync #(.W(2)) u_req_sync (
        .clk(mem_clk),
        .rst_n(link_rst_n),
        .d({bq.clr_req, bq.cfg_req}),
        .q(req_s)
    );

    // Flags are independent levels; the power state is Gray coded, but run to active power-down and back moves both bits at once
    ddrtc_sync #(.W(11)) u_stat_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({term_active, lq.pstate == ddrtc_pkg::DDRTC_SELF_REF ||
            lq.pstate == ddrtc_pkg::DDRTC_PDN_PRE, lq.pstate, lq.viol, lq.cfg_ack}),
        .q(stat_s)
    );

    assign busy = bq.cfg_req != stat_s[0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = bq.rdata;

    // Bus side
    always_comb begin
        bn = bq;
        bn.dp_valid = hsel && hready && htrans[1];
        bn.dp_write = hwrite;
        bn.dp_addr = haddr[7:0];
        if (bq.dp_valid && bq.dp_write) begin
            if (reg_sel(bq.dp_addr) == 2'h0 && !busy) begin
                // Refused while the previous word is still crossing, so it stays stable
                bn.cfg.additive_latency = hwdata[`DDRTC_AL_MSB:`DDRTC_AL_LSB];
                bn.cfg.bl8 = hwdata[`DDRTC_BL8_BIT];
                bn.cfg.write_recovery = hwdata[`DDRTC_WR_MSB:`DDRTC_WR_LSB];
                bn.cfg.strobe_single = hwdata[`DDRTC_STROBE_BIT];
                bn.cfg.slow_exit = hwdata[`DDRTC_SLOWX_BIT];
                bn.cfg.speed_fast = hwdata[`DDRTC_GRADE_BIT];
                bn.cfg_req = ~bq.cfg_req;
            end else if (reg_sel(bq.dp_addr) == 2'h2 && hwdata[`DDRTC_CLR_BIT]) begin
                bn.clr_req = ~bq.clr_req;
            end
        end
        if (bn.dp_valid && !hwrite) begin
            bn.rdata = 32'h0000_0000;
            if (reg_sel(haddr[7:0]) == 2'h0) begin
                bn.rdata[`DDRTC_AL_MSB:`DDRTC_AL_LSB] = bn.cfg.additive_latency;
                bn.rdata[`DDRTC_BL8_BIT] = bn.cfg.bl8;
                bn.rdata[`DDRTC_WR_MSB:`DDRTC_WR_LSB] = bn.cfg.write_recovery;
                bn.rdata[`DDRTC_STROBE_BIT] = bn.cfg.strobe_single;
                bn.rdata[`DDRTC_SLOWX_BIT] = bn.cfg.slow_exit;
                bn.rdata[`DDRTC_GRADE_BIT] = bn.cfg.speed_fast;
            end else if (reg_sel(haddr[7:0]) == 2'h1) begin
                bn.rdata[`DDRTC_VIOL_MSB:`DDRTC_VIOL_LSB] = stat_s[6:1];
                bn.rdata[`DDRTC_PST_MSB:`DDRTC_PST_LSB] = stat_s[8:7];
                bn.rdata[`DDRTC_FREQOK_BIT] = stat_s[9];
                bn.rdata[`DDRTC_TERM_BIT] = stat_s[10];
                bn.rdata[`DDRTC_BUSY_BIT] = bn.cfg_req != stat_s[0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bq <= '{cfg: `DDRTC_CFG_RST, rdata: 32'h0000_0000, dp_addr: 8'h00, default: 1'b0};
        end else begin
            bq <= bn;
        end
    end

    // Link side
    assign burst_half = lq.cfg.bl8 ? 5'h04 : 5'h02;
    assign xard_slow = lq.cfg.speed_fast ? 4'(`DDRTC_XARDS_FAST_BASE) : 4'(`DDRTC_XARDS_SLOW_BASE);
    assign cke_rise = link_pins.cke && !lq.cke_prev;
    assign cke_fall = !link_pins.cke && lq.cke_prev;
    assign bank_hit = link_pins.ap ? 8'hFF : (8'h01 << link_pins.bank);

    always_comb begin
        ln = lq;
        cmd = decode_cmd(link_pins);
        vset = '0;
        rd_load = 5'({2'b00, lq.cfg.additive_latency}) + burst_half - 5'h01;
        if (rd_load < 5'(`DDRTC_NRTP_CYC - 1)) begin
            rd_load = 5'(`DDRTC_NRTP_CYC - 1);
        end
        if (req_s[0] != lq.cfg_ack) begin
            ln.cfg = bq.cfg;
            ln.cfg_ack = req_s[0];
        end
        for (int i = 0; i < 8; i++) begin
            if (lq.pre_cnt[i] != 5'h00) begin
                ln.pre_cnt[i] = lq.pre_cnt[i] - 5'h01;
            end
            if (lq.act_cnt[i] != 5'h00) begin
                ln.act_cnt[i] = lq.act_cnt[i] - 5'h01;
            end
        end
        if (lq.wtr_cnt != 2'h0) begin
            ln.wtr_cnt = lq.wtr_cnt - 2'h1;
        end
        if (lq.xp_cnt != 2'h0) begin
            ln.xp_cnt = lq.xp_cnt - 2'h1;
        end
        if (lq.xrd_cnt != 4'h0) begin
            ln.xrd_cnt = lq.xrd_cnt - 4'h1;
        end
        // Clock enable hold, counted in registered edges
        ln.cke_prev = link_pins.cke;
        if (link_pins.cke != lq.cke_prev) begin
            if (lq.cke_hold < 2'(`DDRTC_CKE_HOLD_CYC)) begin
                vset.cke_hold = 1'b1;
            end
            ln.cke_hold = 2'h1;
        end else if (lq.cke_hold < 2'(`DDRTC_CKE_HOLD_CYC)) begin
            ln.cke_hold = lq.cke_hold + 2'h1;
        end
        // Termination control
        ln.odt_prev = link_pins.odt;
        if (link_pins.odt && !lq.odt_prev) begin
            ln.on_cnt = 2'(`DDRTC_AOND_CYC);
            ln.off_cnt = 2'h0;
            ln.off_due = 1'b0;
        end else if (lq.on_cnt != 2'h0) begin
            ln.on_cnt = lq.on_cnt - 2'h1;
            if (lq.on_cnt == 2'h1) begin
                ln.term_on = 1'b1;
            end
        end
        if (!link_pins.odt && lq.odt_prev) begin
            ln.off_cnt = 2'(`DDRTC_AOFD_CYC);
            ln.on_cnt = 2'h0;
        end else if (lq.off_cnt != 2'h0) begin
            ln.off_cnt = lq.off_cnt - 2'h1;
            if (lq.off_cnt == 2'h1) begin
                ln.off_due = 1'b1;
            end
        end
        if (lq.off_due) begin
            ln.term_on = 1'b0;
            ln.off_due = 1'b0;
        end
        // Power states; only entry and exit edges move it
        case (lq.pstate)
            ddrtc_pkg::DDRTC_RUN: begin
                if (cke_fall) begin
                    if (cmd == ddrtc_pkg::DDRTC_REF) begin
                        ln.pstate = ddrtc_pkg::DDRTC_SELF_REF;
                    end else if (lq.open_bank != 8'h00) begin
                        ln.pstate = ddrtc_pkg::DDRTC_PDN_ACT;
                    end else begin
                        ln.pstate = ddrtc_pkg::DDRTC_PDN_PRE;
                    end
                end
            end
            ddrtc_pkg::DDRTC_PDN_PRE, ddrtc_pkg::DDRTC_PDN_ACT: begin
                if (cke_rise) begin
                    ln.pstate = ddrtc_pkg::DDRTC_RUN;
                    ln.xp_cnt = 2'(`DDRTC_XP_CYC - 1);
                    ln.xrd_cnt = 4'(`DDRTC_XARD_CYC - 1);
                    if (lq.pstate == ddrtc_pkg::DDRTC_PDN_ACT && lq.cfg.slow_exit) begin
                        // Slow exit never shorter than the fast figure
                        ln.xrd_cnt = xard_slow - 4'({1'b0, lq.cfg.additive_latency}) - 4'h1;
                        if (xard_slow < 4'({1'b0, lq.cfg.additive_latency}) + 4'(`DDRTC_XARD_CYC)) begin
                            ln.xrd_cnt = 4'(`DDRTC_XARD_CYC - 1);
                        end
                    end
                end
            end
            ddrtc_pkg::DDRTC_SELF_REF: begin
                if (cke_rise) begin
                    ln.pstate = ddrtc_pkg::DDRTC_RUN;
                end
            end
            default: ln.pstate = ddrtc_pkg::DDRTC_RUN;
        endcase
        // Command checks use the counters as they stood before this edge
        if (link_pins.cke && lq.cke_prev && lq.pstate == ddrtc_pkg::DDRTC_RUN) begin
            if (cmd != ddrtc_pkg::DDRTC_NOP && lq.xp_cnt != 2'h0) begin
                vset.pd_exit = 1'b1;
            end
            case (cmd)
                ddrtc_pkg::DDRTC_ACT: begin
                    if (lq.act_cnt[link_pins.bank] != 5'h00) begin
                        vset.dal = 1'b1;
                    end
                    ln.open_bank[link_pins.bank] = 1'b1;
                    ln.pre_cnt[link_pins.bank] = 5'(`DDRTC_NRAS_CYC - 1);
                end
                ddrtc_pkg::DDRTC_RD: begin
                    if (lq.wtr_cnt != 2'h0) begin
                        vset.wtr = 1'b1;
                    end
                    if (lq.xrd_cnt != 4'h0) begin
                        vset.pd_exit = 1'b1;
                    end
                    if (lq.pre_cnt[link_pins.bank] < rd_load) begin
                        ln.pre_cnt[link_pins.bank] = rd_load;
                    end
                    if (link_pins.ap) begin
                        ln.open_bank[link_pins.bank] = 1'b0;
                        ln.act_cnt[link_pins.bank] = rd_load + 5'(`DDRTC_NRP_CYC);
                    end
                end
                ddrtc_pkg::DDRTC_WR: begin
                    // Strobe postamble length is not checked: a long one only costs turnaround
                    ln.wtr_cnt = 2'(`DDRTC_WTR_CYC - 1);
                    if (link_pins.ap) begin
                        ln.open_bank[link_pins.bank] = 1'b0;
                        ln.act_cnt[link_pins.bank] = 5'({2'b00, lq.cfg.write_recovery}) +
                            5'(`DDRTC_NRP_CYC) - 5'h01;
                    end
                end
                ddrtc_pkg::DDRTC_PRE: begin
                    for (int i = 0; i < 8; i++) begin
                        if (bank_hit[i]) begin
                            if (lq.pre_cnt[i] != 5'h00) begin
                                vset.rtp = 1'b1;
                            end
                            ln.open_bank[i] = 1'b0;
                            ln.act_cnt[i] = 5'(`DDRTC_NRP_CYC - 1);
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Refresh interval; the device refreshes itself in self refresh
        if (cmd == ddrtc_pkg::DDRTC_REF || lq.pstate == ddrtc_pkg::DDRTC_SELF_REF) begin
            ln.ref_cnt = 16'h0000;
        end else if (lq.ref_cnt < 16'(`DDRTC_REFI_CYC)) begin
            ln.ref_cnt = lq.ref_cnt + 16'h0001;
        end else begin
            vset.refresh = 1'b1;
        end
        // Clear toggle, then new events: a set in the clear edge survives
        ln.clr_prev = req_s[1];
        if (req_s[1] != lq.clr_prev) begin
            ln.viol = '0;
        end
        ln.viol = ln.viol | vset;
    end

    always_ff @(posedge mem_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lq <= '{cfg: `DDRTC_CFG_RST, pstate: ddrtc_pkg::DDRTC_RUN, cke_hold: 2'h3,
                   default: '0};
        end else begin
            lq <= ln;
        end
    end

    // Half-period step of the turn-off
    always_ff @(negedge mem_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            off_half_reg <= 1'b0;
        end else begin
            off_half_reg <= lq.off_due;
        end
    end

    assign term_active = lq.term_on && !off_half_reg;
    assign diff_strobe_en = !lq.cfg.strobe_single;

endmodule : ddrtc_top

// file: test/ddrtc_checker.sv
// Port assertions of the DDR timing block
`timescale 1ns/1ps
module ddrtc_checker (
    // Bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Link side
    input wire logic mem_clk,
    input wire ddrtc_pkg::ddrtc_pins_t link_pins,
    input wire logic term_active,
    input wire logic diff_strobe_en
);
    wire rd_ap = hsel && hready && htrans[1] && !hwrite;
    wire odt = link_pins.odt;
    property p_ready;
        @(posedge hclk) disable iff (!hresetn) hreadyout;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay;
        @(posedge hclk) disable iff (!hresetn) !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    // Read data may only move after a read address phase
    property p_rdata;
        @(posedge hclk) disable iff (!hresetn) !$past(rd_ap) |-> $stable(hrdata);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved");
    property p_on;
        @(posedge mem_clk) disable iff (!hresetn)
        $rose(odt) && !term_active |-> !term_active [*3] ##1 term_active;
    endproperty
    a_on: assert property (p_on) else $error("termination on late or early");
    property p_off;
        @(posedge mem_clk) disable iff (!hresetn)
        $fell(odt) && term_active |-> term_active [*3] ##1 !term_active;
    endproperty
    a_off: assert property (p_off) else $error("termination off late or early");
    property p_on_cause;
        @(posedge mem_clk) disable iff (!hresetn)
        $rose(term_active) |-> $past(odt, 3) && !$past(odt, 4);
    endproperty
    a_on_cause: assert property (p_on_cause) else $error("termination on uncaused");
    property p_off_cause;
        @(posedge mem_clk) disable iff (!hresetn)
        $fell(term_active) |-> !$past(odt, 3) && $past(odt, 4);
    endproperty
    a_off_cause: assert property (p_off_cause) else $error("termination off uncaused");
    property p_hold_on;
        @(posedge mem_clk) disable iff (!hresetn)
        odt && $past(odt) && $past(odt, 2) && $past(odt, 3) |-> term_active;
    endproperty
    a_hold_on: assert property (p_hold_on) else $error("termination dropped");
    property p_hold_off;
        @(posedge mem_clk) disable iff (!hresetn)
        !odt && !$past(odt) && !$past(odt, 2) && !$past(odt, 3) |-> !term_active;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("termination stuck on");
    c_on: cover property (@(posedge mem_clk) $rose(term_active));
    c_off: cover property (@(posedge mem_clk) $fell(term_active));
    c_read: cover property (@(posedge hclk) rd_ap);
endmodule : ddrtc_checker

bind ddrtc_top ddrtc_checker chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .mem_clk(mem_clk), .link_pins(link_pins), .term_active(term_active),
    .diff_strobe_en(diff_strobe_en));

// file: test/ddrtc_ctrl_model.sv
// Behavioural memory controller driving link clock and command pins
`timescale 1ns/1ps
module ddrtc_ctrl_model (
    // Link clock and pins
    output logic mem_clk,
    output ddrtc_pkg::ddrtc_pins_t link_pins
);
    // Free-running at a fixed rate: reset release and refresh ageing need edges
    initial begin
        mem_clk = 1'b0;
        #37;
        forever #80 mem_clk = ~mem_clk;
    end
    initial link_pins = 10'h270;
    // Caller sits just after an edge; NOPs keep clock enable and termination
    task automatic send(input ddrtc_pkg::ddrtc_pins_t p, input int gap);
        link_pins <= p;
        @(posedge mem_clk);
        if (gap > 1) begin
            link_pins <= p | 10'h070;
        end
        repeat (gap - 1) @(posedge mem_clk);
    endtask : send
endmodule : ddrtc_ctrl_model

// file: test/testbench.sv
// Self-checking bench for the DDR timing block
`timescale 1ns/1ps
module testbench;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    wire hready;
    logic hresp;
    logic [31:0] hrdata;
    logic mem_clk;
    ddrtc_pkg::ddrtc_pins_t link_pins;
    logic term_active;
    logic diff_strobe_en;
    logic dp_rd = 1'b0;
    logic [31:0] cfg;
    int failures;
    int n_compared;
    int al;
    int sx;
    int wr;
    logic [31:0] eq[$];
    logic [31:0] mq[$];

    ddrtc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .mem_clk(mem_clk),
        .link_pins(link_pins), .term_active(term_active), .diff_strobe_en(diff_strobe_en));
    ddrtc_ctrl_model ctl_u (.mem_clk(mem_clk), .link_pins(link_pins));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : bus

    // Every helper built on bus ends just after a link edge, ready for the next command
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        mq.push_back(m);
        eq.push_back(e);
        bus(1'b0, a, 32'h00000000);
        @(posedge mem_clk);
    endtask : rd

    // Status lags the link, so give the crossing time first
    task automatic chk(input logic [31:0] m, input logic [31:0] e);
        repeat (6) @(posedge mem_clk);
        rd(8'h04, m, e);
    endtask : chk

    task automatic clr();
        bus(1'b1, 8'h08, 32'h00000001);
        repeat (6) @(posedge mem_clk);
    endtask : clr

    task automatic go(input logic ck, input logic ot, input logic [2:0] c, input logic ap,
            input logic [2:0] ba, input int gap);
        ctl_u.send({ck, ot, 1'b0, c, ap, ba}, gap);
    endtask : go

    always @(posedge hclk) begin
        if (dp_rd) begin
            check(hrdata & mq.pop_front(), eq.pop_front());
        end
        dp_rd <= hsel && hready && htrans[1] && !hwrite;
    end

    initial begin
        #300000;
        failures++;
        end_sim();
    end

    initial begin
        // Scheduled so every asynchronous reset sees a falling edge at time zero
        hresetn <= 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        failures = 0;
        n_compared = 0;
        void'($urandom(51363));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge mem_clk);
        rd(8'h00, 32'hFFFFFFFF, 32'h00000000);
        chk(32'h00001F3F, 32'h00000000);
        check({31'h0, diff_strobe_en}, 32'h00000001);
        al = $urandom % 4;
        wr = 2 + $urandom % 3;
        cfg = {18'h0, 1'($urandom), 2'h2, 1'($urandom), 3'h0, 3'(wr), 1'b1, 3'(al)};
        sx = (cfg[13] ? 7 : 8) - al;
        bus(1'b1, 8'h00, cfg);
        repeat (10) @(posedge mem_clk);
        chk(32'h00001000, 32'h00000000);
        rd(8'h00, 32'h0000347F, cfg);
        check({31'h0, diff_strobe_en}, {31'h0, ~cfg[10]});
        rd(8'h40, 32'hFFFFFFFF, 32'h00000000);
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rd(8'h00, 32'h0000347F, cfg);
        for (int bad = 1; bad >= 0; bad--) begin
            clr();
            go(1, 0, 3'b011, 0, 3'h1, 2);
            go(1, 0, 3'b100, 0, 3'h1, 2 - bad);
            go(1, 0, 3'b101, 0, 3'h1, al + 4 - bad);
            go(1, 0, 3'b010, 0, 3'h1, 2);
            chk(32'h0000001F, 32'(bad * 6));
            clr();
            go(1, 0, 3'b011, 0, 3'h3, 2);
            go(1, 0, 3'b100, 1, 3'h3, wr + 1 - bad);
            go(1, 0, 3'b011, 0, 3'h3, 2);
            go(1, 0, 3'b010, 0, 3'h3, 2);
            chk(32'h0000001F, 32'(bad * 8));
            clr();
            go(1, 0, 3'b011, 0, 3'h2, 2);
            go(1, 0, 3'b101, 1, 3'h2, al + 5 - bad);
            go(1, 0, 3'b011, 0, 3'h2, 2);
            go(1, 0, 3'b010, 0, 3'h2, 2);
            chk(32'h0000001F, 32'(bad * 8));
            clr();
            go(1, 0, 3'b011, 0, 3'h4, 2);
            go(0, 0, 3'b111, 0, 3'h4, 4);
            go(1, 0, 3'b111, 0, 3'h4, sx - bad);
            go(1, 0, 3'b101, 0, 3'h4, al + 4);
            go(1, 0, 3'b010, 0, 3'h4, 3);
            chk(32'h0000001F, 32'(bad * 16));
        end
        clr();
        go(1, 0, 3'b010, 1, 3'h0, 3);
        go(0, 0, 3'b111, 0, 3'h0, 4);
        chk(32'h0000071F, 32'h00000500);
        go(1, 0, 3'b111, 0, 3'h0, 2);
        go(0, 0, 3'b111, 0, 3'h0, 3);
        go(1, 0, 3'b111, 0, 3'h0, 4);
        chk(32'h0000001F, 32'h00000001);
        go(0, 0, 3'b001, 0, 3'h0, 4);
        chk(32'h00000700, 32'h00000600);
        go(1, 0, 3'b111, 0, 3'h0, 4);
        go(1, 1, 3'b111, 0, 3'h0, 6);
        chk(32'h00000800, 32'h00000800);
        go(1, 0, 3'b111, 0, 3'h0, 6);
        chk(32'h00000800, 32'h00000000);
        go(1, 0, 3'b001, 0, 3'h0, 2);
        clr();
        chk(32'h00000020, 32'h00000000);
        repeat (60) @(posedge mem_clk);
        chk(32'h00000020, 32'h00000020);
        end_sim();
    end
endmodule : testbench
